// ===== rtl/ecsr_flag_cell.v
/*
  One volatile safety flag: set by an event, zeroed by a clear or by the
  start of a new operation unless sticky. Assumes one clock, synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module ecsr_flag_cell (
  input wire mclk_in,
  input wire rst_in,
  input wire set_in,
  input wire clear_in,
  input wire refresh_in,
  input wire sticky_in,
  output reg flag_q_out
);

  // Set beats clear so an event landing on a clear is never lost
  always @(posedge mclk_in) begin
    if (rst_in) begin
      flag_q_out <= 1'b0;
    end else if (set_in) begin
      flag_q_out <= 1'b1;
    end else if (clear_in || (refresh_in && !sticky_in)) begin
      flag_q_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/ecsr_map.vh
/*
  Constants for the configuration, safety and volatile register block:
  instruction codes, field positions, reset values and serial framing counts.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef ECSR_MAP_VH
`define ECSR_MAP_VH

// Instruction codes
`define ECSR_OP_WRITE_STATUS_CONFIG 8'h01
`define ECSR_OP_READ_CONFIG_SAFETY 8'h15
`define ECSR_OP_READ_VOLATILE 8'h85
`define ECSR_OP_WRITE_VOLATILE 8'h81
`define ECSR_OP_CLEAR_FLAGS 8'h50
`define ECSR_OP_READ_PARAM_TABLE 8'h5A

// Configuration byte fields
`define ECSR_CFG_DRV_HI 6
`define ECSR_CFG_DRV_LO 5
`define ECSR_CFG_ID_LOCK 0
`define ECSR_DRV_RESET 2'h3
`define ECSR_ID_LOCK_RESET 1'h0

// Drive strength encodings
`define ECSR_DRV_HIGH 2'h0
`define ECSR_DRV_MEDIUM 2'h1
`define ECSR_DRV_LOW 2'h2
`define ECSR_DRV_DEFAULT 2'h3

// Safety byte fields, b7 down to b0
`define ECSR_SF_PROT_MODIFY 7
`define ECSR_SF_POWERUP 6
`define ECSR_SF_ERASE 5
`define ECSR_SF_PROGRAM 4
`define ECSR_SF_SINGLE_CORR 3
`define ECSR_SF_DOUBLE_CORR 2
`define ECSR_SF_TRIPLE_DET 1
`define ECSR_SF_TRIPLE_STICKY 0
`define ECSR_SF_COUNT 8

// Volatile byte fields and reset values
`define ECSR_VOL_BUF_EN 1
`define ECSR_VOL_BUF_FULL 0
`define ECSR_BUF_EN_RESET 1'h0
`define ECSR_BUF_FULL_RESET 1'h1

// Serial framing
`define ECSR_BYTE_CNT_W 3
`define ECSR_BYTE_CNT_MAX 3'h7
`define ECSR_BYTES_WRITE_STATUS_CONFIG_CMD_TWO 3'h3
`define ECSR_BYTES_WRITE_VOLATILE_CMD 3'h2
`define ECSR_BYTES_OPCODE 3'h1
`define ECSR_BYTES_ADDR_END 3'h4
`define ECSR_BYTES_DUMMY_END 3'h5
`define ECSR_LAST_BIT 3'h7

// Parameter table
`define ECSR_TABLE_AW 9
`define ECSR_TABLE_DEPTH 512

`endif

// ===== rtl/ecsr_regs.v
/*
  Configuration, safety and volatile buffer-control registers of a serial
  page memory, reached over the serial instruction port.
  Assumes serial pins are already synchronous to mclk_in and that the serial
  clock is at most a quarter of mclk_in. Array events arrive as one-cycle
  pulses from the memory core, which also supplies the write enable latch.
*/
// What this block does
// - Read config byte repeatedly on read command
// - Second write-status byte updates drive bits
// - Drive at b6,b5; id lock at b0
// - Drive code sets output strength; default 11
// - Id lock gates id page; two-byte write
// - Read-only eight-bit safety flags, looped read
// - Protected modify flag sticky until clear/reset or power-up success
// - Power-up flag refreshed; clear command zeroes
// - Power-up error makes status read ones
// - Erase flag reflects each erase result
// - Program flag per operation; sticky buffered
// - Single-bit correction flag per operation
// - Double-bit correction flag per operation
// - Triple-bit detection flag per operation
// - Sticky triple detection until clear/reset
// - Flags accumulate within one read
// - Volatile byte read; enable at b1
// - Buffer enable allows program decode while busy if buffer not full
// - Buffer full bit; forced when disabled
// - Holds 512-byte parameter table, readable
// - Opcode 15h returns config then safety
// - Opcodes 85h read, 81h write volatile
// - Opcode 50h clears safety flags
// - Volatile write refused without write enable
`timescale 1ns/1ns
`default_nettype none
`include "ecsr_map.vh"

module ecsr_regs (
  input wire mclk_in,
  input wire rst_in,
  input wire spi_sck_in,
  input wire spi_cs_n_in,
  input wire spi_mosi_in,
  output reg spi_miso_out,
  output reg spi_miso_oe_n_out,
  input wire write_enable_latch_in,
  input wire soft_reset_in,
  input wire powerup_done_in,
  input wire powerup_fail_in,
  input wire protected_modify_in,
  input wire erase_start_in,
  input wire erase_fail_in,
  input wire program_start_in,
  input wire program_fail_in,
  input wire read_start_in,
  input wire single_correct_in,
  input wire double_correct_in,
  input wire triple_detect_in,
  input wire program_busy_in,
  input wire buffer_load_in,
  input wire buffer_release_in,
  input wire table_load_we_in,
  input wire [`ECSR_TABLE_AW-1:0] table_load_addr_in,
  input wire [7:0] table_load_data_in,
  output reg [1:0] drive_strength_out,
  output reg id_page_lock_out,
  output reg [7:0] safety_flags_out,
  output reg status_force_ones_out,
  output reg buffer_mode_enable_out,
  output reg buffer_full_status_out,
  output reg page_program_decode_out,
  output reg write_enable_clear_out
);

  localparam [2:0] ST_OPCODE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_DATA_IN = 3'h2;
  localparam [2:0] ST_DATA_OUT = 3'h3;
  localparam [2:0] ST_WAIT = 3'h4;

  reg sck_q;
  reg cs_n_q;
  reg [2:0] state_q;
  reg [2:0] bit_cnt_q;
  reg [`ECSR_BYTE_CNT_W-1:0] byte_cnt_q;
  reg [7:0] rx_sh_q;
  reg [7:0] opcode_q;
  reg [7:0] data1_q;
  reg [7:0] data2_q;
  reg [7:0] tx_sh_q;
  reg out_sel_q;
  reg [`ECSR_TABLE_AW-1:0] table_addr_q;
  reg drive_hi_q;
  reg drive_lo_q;
  reg id_lock_q;
  reg buf_en_q;
  reg buf_full_q;
  reg clear_flags_q;
  reg [7:0] table_mem [0:`ECSR_TABLE_DEPTH-1];

  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire [7:0] rx_byte;
  wire byte_done;
  wire [7:0] cfg_byte;
  wire [7:0] safety_byte;
  wire [7:0] vol_byte;
  reg [7:0] next_tx;
  wire [`ECSR_SF_COUNT-1:0] flag_set;
  wire [`ECSR_SF_COUNT-1:0] flag_clear;
  wire [`ECSR_SF_COUNT-1:0] flag_refresh;
  wire [`ECSR_SF_COUNT-1:0] flag_sticky;
  wire [`ECSR_SF_COUNT-1:0] flag_q;
  wire flag_wipe;
  wire ecc_refresh;
  wire powerup_ok;

  // Edge detection on the sampled serial pins
  assign sck_rise = spi_sck_in && !sck_q;
  assign sck_fall = !spi_sck_in && sck_q;
  assign cs_rise = spi_cs_n_in && !cs_n_q;
  assign rx_byte = {rx_sh_q[6:0], spi_mosi_in};
  assign byte_done = sck_rise && !spi_cs_n_in && (bit_cnt_q == `ECSR_LAST_BIT);

  // Read images; don't-care bits read as zero
  assign cfg_byte = {1'b0, drive_hi_q, drive_lo_q, 4'h0, id_lock_q};
  assign safety_byte = flag_q;
  assign vol_byte = {6'h00, buf_en_q, buf_full_q};

  always @(posedge mclk_in) begin
    if (rst_in) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q <= spi_sck_in;
      cs_n_q <= spi_cs_n_in;
    end
  end

  // Byte picked for the next output byte; looping rolls over forever
  always @* begin
    next_tx = 8'h00;
    case (opcode_q)
      `ECSR_OP_READ_CONFIG_SAFETY: begin
        next_tx = out_sel_q ? safety_byte : cfg_byte;
      end
      `ECSR_OP_READ_VOLATILE: begin
        next_tx = vol_byte;
      end
      `ECSR_OP_READ_PARAM_TABLE: begin
        next_tx = table_mem[table_addr_q];
      end
      default: begin
        next_tx = 8'h00;
      end
    endcase
  end

  // Factory load port for the parameter table
  always @(posedge mclk_in) begin
    if (table_load_we_in) begin
      table_mem[table_load_addr_in] <= table_load_data_in;
    end
  end

  // Instruction decoder: bits in on rising clock, MSB first
  always @(posedge mclk_in) begin
    if (rst_in || spi_cs_n_in) begin
      state_q <= ST_OPCODE;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= {`ECSR_BYTE_CNT_W{1'b0}};
      rx_sh_q <= 8'h00;
      if (rst_in) begin
        opcode_q <= 8'h00;
        data1_q <= 8'h00;
        data2_q <= 8'h00;
        table_addr_q <= {`ECSR_TABLE_AW{1'b0}};
      end
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_sh_q <= rx_byte;
      if (byte_done) begin
        if (byte_cnt_q != `ECSR_BYTE_CNT_MAX) begin
          byte_cnt_q <= byte_cnt_q + 3'h1;
        end
        case (state_q)
          ST_OPCODE: begin
            opcode_q <= rx_byte;
            case (rx_byte)
              `ECSR_OP_READ_CONFIG_SAFETY, `ECSR_OP_READ_VOLATILE: begin
                state_q <= ST_DATA_OUT;
              end
              `ECSR_OP_WRITE_STATUS_CONFIG, `ECSR_OP_WRITE_VOLATILE: begin
                state_q <= ST_DATA_IN;
              end
              `ECSR_OP_READ_PARAM_TABLE: begin
                state_q <= ST_ADDR;
              end
              `ECSR_OP_CLEAR_FLAGS: begin
                state_q <= ST_WAIT;
              end
              default: begin
                state_q <= ST_WAIT; // Unknown code waits for deselect
              end
            endcase
          end
          ST_ADDR: begin
            // Three address bytes then one dummy; low bits index the table
            if (byte_cnt_q < `ECSR_BYTES_ADDR_END) begin
              table_addr_q <= {table_addr_q[0], rx_byte};
            end
            if (byte_cnt_q == `ECSR_BYTES_ADDR_END) begin
              state_q <= ST_DATA_OUT;
            end
          end
          ST_DATA_IN: begin
            if (byte_cnt_q == `ECSR_BYTES_OPCODE) begin
              data1_q <= rx_byte;
            end else if (byte_cnt_q == `ECSR_BYTES_WRITE_VOLATILE_CMD) begin
              data2_q <= rx_byte;
            end
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
    end else if (sck_fall && (state_q == ST_DATA_OUT) && (bit_cnt_q == 3'h0)) begin
      // Table address steps once per byte sent, wrapping at the end
      if (opcode_q == `ECSR_OP_READ_PARAM_TABLE) begin
        table_addr_q <= table_addr_q + {{(`ECSR_TABLE_AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Output shifter: bits out on falling clock, MSB first
  always @(posedge mclk_in) begin
    if (rst_in || spi_cs_n_in) begin
      tx_sh_q <= 8'h00;
      out_sel_q <= 1'b0;
      spi_miso_out <= 1'b0;
      spi_miso_oe_n_out <= 1'b1;
    end else if (sck_fall && (state_q == ST_DATA_OUT)) begin
      spi_miso_oe_n_out <= 1'b0;
      if (bit_cnt_q == 3'h0) begin
        spi_miso_out <= next_tx[7];
        tx_sh_q <= {next_tx[6:0], 1'b0};
        out_sel_q <= !out_sel_q;
      end else begin
        spi_miso_out <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  // Nonvolatile configuration; written only when deselect ends two data bytes
  always @(posedge mclk_in) begin
    if (rst_in) begin
      {drive_hi_q, drive_lo_q} <= `ECSR_DRV_RESET;
      id_lock_q <= `ECSR_ID_LOCK_RESET;
    end else if (cs_rise && (opcode_q == `ECSR_OP_WRITE_STATUS_CONFIG) &&
                 (byte_cnt_q == `ECSR_BYTES_WRITE_STATUS_CONFIG_CMD_TWO) && (bit_cnt_q == 3'h0) &&
                 write_enable_latch_in) begin
      drive_hi_q <= data2_q[`ECSR_CFG_DRV_HI];
      drive_lo_q <= data2_q[`ECSR_CFG_DRV_LO];
      id_lock_q <= data2_q[`ECSR_CFG_ID_LOCK];
    end
  end

  // Buffer enable: write enable must be held or the write is dropped
  always @(posedge mclk_in) begin
    if (rst_in || soft_reset_in) begin
      buf_en_q <= `ECSR_BUF_EN_RESET;
    end else if (cs_rise && (opcode_q == `ECSR_OP_WRITE_VOLATILE) &&
                 (byte_cnt_q == `ECSR_BYTES_WRITE_VOLATILE_CMD) && (bit_cnt_q == 3'h0) &&
                 write_enable_latch_in) begin
      buf_en_q <= data1_q[`ECSR_VOL_BUF_EN];
    end
  end

  // Buffer full: held at one while disabled, freed on enable
  always @(posedge mclk_in) begin
    if (rst_in || soft_reset_in || !buf_en_q) begin
      buf_full_q <= `ECSR_BUF_FULL_RESET;
    end else if (buffer_load_in) begin
      buf_full_q <= 1'b1;
    end else if (buffer_release_in || !buffer_mode_enable_out) begin // Copy lags a fresh enable
      buf_full_q <= 1'b0;
    end
  end

  // Clear command acts once the frame ends exactly after its opcode
  always @(posedge mclk_in) begin
    if (rst_in) begin
      clear_flags_q <= 1'b0;
      write_enable_clear_out <= 1'b0;
    end else begin
      clear_flags_q <= cs_rise && (opcode_q == `ECSR_OP_CLEAR_FLAGS) &&
                       (byte_cnt_q == `ECSR_BYTES_OPCODE) && (bit_cnt_q == 3'h0);
      // Successful config or volatile write drops the latch in the core
      write_enable_clear_out <= cs_rise && write_enable_latch_in && (bit_cnt_q == 3'h0) &&
        (((opcode_q == `ECSR_OP_WRITE_STATUS_CONFIG) &&
          (byte_cnt_q == `ECSR_BYTES_WRITE_STATUS_CONFIG_CMD_TWO)) ||
         ((opcode_q == `ECSR_OP_WRITE_VOLATILE) && (byte_cnt_q == `ECSR_BYTES_WRITE_VOLATILE_CMD)));
    end
  end

  // Flag steering; reads never touch the flags, only events and the clear command do
  assign flag_wipe = clear_flags_q || soft_reset_in;
  assign powerup_ok = powerup_done_in && !powerup_fail_in;
  assign ecc_refresh = read_start_in || program_start_in;
  // Per-flag controls packed b7 down to b0, in the order of the safety byte
  assign flag_set = {protected_modify_in, powerup_done_in && powerup_fail_in,
                     erase_fail_in, program_fail_in,
                     single_correct_in, double_correct_in,
                     triple_detect_in, triple_detect_in};
  // Power-up success also drops the modify flag; software reset refreshes the power-up flag
  assign flag_clear = {flag_wipe || powerup_ok, clear_flags_q,
                       {(`ECSR_SF_COUNT-2){flag_wipe}}};
  assign flag_refresh = {1'b0, powerup_done_in || soft_reset_in, erase_start_in,
                         program_start_in, ecc_refresh, ecc_refresh, ecc_refresh, 1'b0};
  // Sticky copy survives later operations; program flag holds while buffering
  assign flag_sticky = {1'b1, 1'b0, 1'b0, buf_en_q, 1'b0, 1'b0, 1'b0, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < `ECSR_SF_COUNT; gi = gi + 1) begin : g_flag
      ecsr_flag_cell u_flag (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(flag_set[gi]),
        .clear_in(flag_clear[gi]),
        .refresh_in(flag_refresh[gi]),
        .sticky_in(flag_sticky[gi]),
        .flag_q_out(flag_q[gi])
      );
    end
  endgenerate

  // Registered copies toward the core; one cycle behind the source flops
  always @(posedge mclk_in) begin
    if (rst_in) begin
      drive_strength_out <= `ECSR_DRV_RESET;
      id_page_lock_out <= `ECSR_ID_LOCK_RESET;
      safety_flags_out <= 8'h00;
      status_force_ones_out <= 1'b0;
      buffer_mode_enable_out <= `ECSR_BUF_EN_RESET;
      buffer_full_status_out <= `ECSR_BUF_FULL_RESET;
      page_program_decode_out <= 1'b1;
    end else begin
      drive_strength_out <= {drive_hi_q, drive_lo_q};
      id_page_lock_out <= id_lock_q;
      safety_flags_out <= flag_q;
      status_force_ones_out <= flag_q[`ECSR_SF_POWERUP];
      buffer_mode_enable_out <= buf_en_q;
      buffer_full_status_out <= buf_full_q;
      // A busy array only takes a new page program into a free buffer
      page_program_decode_out <= !program_busy_in || (buf_en_q && !buf_full_q);
    end
  end

endmodule

`default_nettype wire

// ===== verif/ecsr_regs_chk.sv
/*
  Checker for the register block: flag, write and output-enable timing.
  Assumes the ports of ecsr_regs and a single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module ecsr_regs_chk (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_miso_oe_n_out,
  input wire logic protected_modify_in,
  input wire logic powerup_done_in,
  input wire logic powerup_fail_in,
  input wire logic erase_fail_in,
  input wire logic read_start_in,
  input wire logic single_correct_in,
  input wire logic soft_reset_in,
  input wire logic program_busy_in,
  input wire logic [1:0] drive_strength_out,
  input wire logic write_enable_clear_out,
  input wire logic [7:0] safety_flags_out,
  input wire logic status_force_ones_out,
  input wire logic buffer_mode_enable_out,
  input wire logic buffer_full_status_out,
  input wire logic page_program_decode_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Event pulses reach the flag outputs two edges later; set wins over clear
  a_prot_set: assert property (protected_modify_in |-> ##2 safety_flags_out[7])
    else $error("protected modify flag not set");
  a_puf_error: assert property (powerup_done_in && powerup_fail_in |-> ##2 safety_flags_out[6])
    else $error("power-up error not flagged");
  a_puf_ok: assert property (powerup_done_in && !powerup_fail_in && !protected_modify_in
    |-> ##2 safety_flags_out[7:6] == 2'h0)
    else $error("power-up success left flags set");
  a_status_ones: assert property ($rose(safety_flags_out[6]) |-> ##[0:1] status_force_ones_out)
    else $error("status not forced to ones");
  a_erase_fail: assert property (erase_fail_in |-> ##2 safety_flags_out[5])
    else $error("erase flag not set");
  a_ecc_refresh: assert property (read_start_in && !single_correct_in |-> ##2 !safety_flags_out[3])
    else $error("single correction flag not refreshed");
  // Four idle select cycles keep a pending clear-flags out of the window
  a_sticky_hold: assert property ((spi_cs_n_in [*4]) ##0 (read_start_in && safety_flags_out[0]
    && !soft_reset_in && !$past(soft_reset_in) && !powerup_done_in)
    |-> ##2 (safety_flags_out[0] || $past(soft_reset_in)))
    else $error("sticky triple flag lost on refresh");
  a_drive_write: assert property ($changed(drive_strength_out) |-> $past(write_enable_clear_out))
    else $error("drive changed without accepted write");
  a_oe_idle: assert property (spi_cs_n_in [*3] |-> spi_miso_oe_n_out)
    else $error("output enabled while deselected");
  a_full_forced: assert property (!buffer_mode_enable_out && !$past(buffer_mode_enable_out)
    |-> buffer_full_status_out)
    else $error("buffer not full while disabled");
  a_decode_gate: assert property ((!buffer_mode_enable_out && program_busy_in) [*3]
    |-> !page_program_decode_out)
    else $error("program decoded while busy without buffer");
  cover property (!spi_miso_oe_n_out);
  cover property (write_enable_clear_out);
  cover property (safety_flags_out == 8'hFF);
  cover property ($rose(buffer_full_status_out) && buffer_mode_enable_out);
endmodule
bind ecsr_regs ecsr_regs_chk chk (.mclk_in, .rst_in, .spi_cs_n_in, .spi_miso_oe_n_out,
  .protected_modify_in, .powerup_done_in, .powerup_fail_in, .erase_fail_in, .read_start_in,
  .single_correct_in, .soft_reset_in, .program_busy_in, .drive_strength_out,
  .write_enable_clear_out, .safety_flags_out, .status_force_ones_out,
  .buffer_mode_enable_out, .buffer_full_status_out, .page_program_decode_out);
`default_nettype wire

// ===== verif/ecsr_regs_tb_top.sv
/*
  Self-checking bench for ecsr_regs: register writes, reads and safety flags.
  Assumes the serial host model and a 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ecsr_map.vh"
module ecsr_regs_tb_top;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic write_enable_latch = 1'b0;
  logic pu_fail = 1'b0;
  logic busy = 1'b0;
  logic [12:0] ev = 13'h0000;
  logic tbl_we = 1'b0;
  logic [8:0] tbl_addr = 9'h000;
  logic [7:0] tbl_data = 8'h00;
  logic sck, cs_n, mosi, miso, oe_n, lock, force1, ben, bfull, dec, wec;
  logic [1:0] drv;
  logic [7:0] sf;
  logic [31:0] rx;
  int err_total = 0;
  int comparisons = 0;
  // Rows: written config byte, drive, lock, byte read back
  logic [18:0] rows [5] = '{{8'h1E, 2'h0, 1'h0, 8'h00}, {8'h21, 2'h1, 1'h1, 8'h21},
    {8'hC0, 2'h2, 1'h0, 8'h40}, {8'hFF, 2'h3, 1'h1, 8'h61}, {8'h60, 2'h3, 1'h0, 8'h60}};
  initial forever #20 mclk_in = ~mclk_in;
  ecsr_regs dut (.mclk_in(mclk_in), .rst_in(rst_in), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_n_out(oe_n),
    .write_enable_latch_in(write_enable_latch), .soft_reset_in(ev[1]), .powerup_done_in(ev[2]),
    .powerup_fail_in(pu_fail), .protected_modify_in(ev[0]), .erase_start_in(ev[3]),
    .erase_fail_in(ev[4]), .program_start_in(ev[5]), .program_fail_in(ev[6]),
    .read_start_in(ev[7]), .single_correct_in(ev[8]), .double_correct_in(ev[9]),
    .triple_detect_in(ev[10]), .program_busy_in(busy), .buffer_load_in(ev[11]),
    .buffer_release_in(ev[12]), .table_load_we_in(tbl_we), .table_load_addr_in(tbl_addr),
    .table_load_data_in(tbl_data), .drive_strength_out(drv), .id_page_lock_out(lock),
    .safety_flags_out(sf), .status_force_ones_out(force1), .buffer_mode_enable_out(ben),
    .buffer_full_status_out(bfull), .page_program_decode_out(dec),
    .write_enable_clear_out(wec));
  ecsr_spi_host host (.mclk_in(mclk_in), .miso_in(miso), .sck_out(sck), .cs_n_out(cs_n),
    .mosi_out(mosi));
  // Core side: an accepted write drops the latch, as the real core would
  always @(posedge mclk_in) begin
    if (wec === 1'b1) write_enable_latch <= #1 1'b0;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input logic [12:0] m);
    ev = m;
    @(posedge mclk_in);
    #1 ev = 13'h0000;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask
  // Write enable then the write, as the host must
  task automatic wr(input logic [31:0] tx, input int n);
    write_enable_latch = 1'b1;
    host.xfer(tx, n, rx);
  endtask
  task automatic rd_flags(input logic [7:0] exp);
    host.xfer({`ECSR_OP_READ_CONFIG_SAFETY, 24'h000000}, 32, rx);
    chk(rx[15:8], exp);
    chk(sf, exp);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    @(posedge mclk_in);
    #1 chk({5'h00, drv, lock}, {5'h00, `ECSR_DRV_DEFAULT, 1'h0});
    chk({4'h0, ben, bfull, oe_n, force1}, 8'h06);
    chk(sf, 8'h00);
    foreach (rows[i]) begin
      wr({8'h00, `ECSR_OP_WRITE_STATUS_CONFIG, 8'h00, rows[i][18:11]}, 24);
      chk({5'h00, drv, lock}, {5'h00, rows[i][10:8]});
      chk({7'h00, write_enable_latch}, 8'h00);
      host.xfer({`ECSR_OP_READ_CONFIG_SAFETY, 24'h000000}, 32, rx);
      chk(rx[23:16], rows[i][7:0]);
      chk(rx[7:0], rows[i][7:0]);
    end
    // Refused writes: latch clear, then a single data byte
    host.xfer({8'h00, `ECSR_OP_WRITE_STATUS_CONFIG, 16'h0001}, 24, rx);
    chk({5'h00, drv, lock}, 8'h06);
    wr({16'h0000, `ECSR_OP_WRITE_STATUS_CONFIG, 8'h01}, 16);
    chk({7'h00, lock}, 8'h00);
    write_enable_latch = 1'b0;
    host.xfer({16'h0000, `ECSR_OP_WRITE_VOLATILE, 8'h02}, 16, rx);
    chk({6'h00, ben, bfull}, 8'h01);
    wr({16'h0000, `ECSR_OP_WRITE_VOLATILE, 8'h02}, 16);
    busy = 1'b1;
    chk({5'h00, ben, bfull, dec}, 8'h05);
    host.xfer({`ECSR_OP_READ_VOLATILE, 24'h000000}, 32, rx);
    chk(rx[15:8], 8'h02);
    chk(rx[7:0], 8'h02);
    pulse(13'h0800);
    chk({7'h00, bfull}, 8'h01);
    pulse(13'h1000);
    chk({7'h00, bfull}, 8'h00);
    pulse(13'h0040);
    pulse(13'h0020);
    chk(sf, 8'h10);
    pulse(13'h0002);
    chk({5'h00, ben, bfull, dec}, 8'h02);
    chk(sf, 8'h00);
    busy = 1'b0;
    // Every flag event over four pulses, then refreshes one by one
    pu_fail = 1'b1;
    pulse(13'h0001);
    pulse(13'h0004);
    pulse(13'h0050);
    pulse(13'h0700);
    rd_flags(8'hFF);
    chk({7'h00, force1}, 8'h01);
    rd_flags(8'hFF);
    pulse(13'h0080);
    chk(sf, 8'hF1);
    pulse(13'h0020);
    chk(sf, 8'hE1);
    pulse(13'h0008);
    chk(sf, 8'hC1);
    pulse(13'h0080);
    pulse(13'h0100);
    pulse(13'h0200);
    chk(sf, 8'hCD);
    host.xfer({24'h000000, `ECSR_OP_CLEAR_FLAGS}, 8, rx);
    chk({force1, sf[6:0]}, 8'h00);
    chk(sf, 8'h00);
    pu_fail = 1'b0;
    pulse(13'h0401);
    chk(sf, 8'h83);
    pulse(13'h0002);
    chk(sf, 8'h00);
    pulse(13'h0001);
    pulse(13'h0004);
    chk(sf, 8'h00);
    // Parameter table: load two entries, read them back after address and dummy
    tbl_we = 1'b1;
    tbl_data = 8'hA5;
    @(posedge mclk_in);
    #1 tbl_addr = 9'h001;
    tbl_data = 8'h3C;
    @(posedge mclk_in);
    #1 tbl_we = 1'b0;
    host.xfer({`ECSR_OP_READ_PARAM_TABLE, 24'h000000}, 56, rx);
    chk(rx[15:8], 8'hA5);
    chk(rx[7:0], 8'h3C);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ===== verif/ecsr_spi_host.sv
/*
  Serial host model: mode 0 frames, eight mclk cycles a bit, MSB first.
  Assumes the caller uses xfer from a process synchronous to mclk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module ecsr_spi_host (
  input wire logic mclk_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out
);
  logic busy_q = 1'b0;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Data line toggles between frames so no stale bit can be relied on
  always @(posedge mclk_in) begin
    if (!busy_q) mosi_out <= ~mosi_out;
  end
  // Sends nbits of tx, top bit first, zeros past 32 bits; clock stays low outside the frame
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    int i;
    int sh;
    rx = 32'h00000000;
    sh = (nbits > 32) ? nbits - 32 : 0;
    @(posedge mclk_in);
    #1 busy_q = 1'b1;
    cs_n_out = 1'b0;
    for (i = nbits - 1; i >= 0; i--) begin
      mosi_out = (i >= sh) ? tx[i - sh] : 1'b0;
      repeat (4) @(posedge mclk_in);
      rx = {rx[30:0], miso_in};
      #1 sck_out = 1'b1;
      repeat (4) @(posedge mclk_in);
      #1 sck_out = 1'b0;
    end
    repeat (4) @(posedge mclk_in);
    #1 cs_n_out = 1'b1;
    busy_q = 1'b0;
    repeat (6) @(posedge mclk_in);
    #1;
  endtask
endmodule
`default_nettype wire
